/* File: hw/lamp_cfg.svh */
`ifndef LAMP_CFG_SVH
`define LAMP_CFG_SVH

// System clock rate in hertz.
`define LAMP_CLK_HZ 40000000
// Start-up hold time in seconds.
`define LAMP_STARTUP_S 10
// Blink rates in hertz; fast red blink rate is chosen.
`define LAMP_FAST_HZ 4
`define LAMP_RUN_HZ 2
`define LAMP_RESTORE_HZ 1
// Half-period counts: a lamp toggles at twice its blink rate.
`define LAMP_FAST_HALF (`LAMP_CLK_HZ / (2 * `LAMP_FAST_HZ))
`define LAMP_RUN_HALF (`LAMP_CLK_HZ / (2 * `LAMP_RUN_HZ))
`define LAMP_RESTORE_HALF (`LAMP_CLK_HZ / (2 * `LAMP_RESTORE_HZ))
`define LAMP_STARTUP_CYC (`LAMP_CLK_HZ * `LAMP_STARTUP_S)
// Register map.
`define LAMP_REG_CTRL 4'h0
`define LAMP_REG_STATUS 4'h4
`define LAMP_REG_LAMPS 4'h8
// Control field positions.
`define LAMP_CTRL_NET_UP 0
`define LAMP_CTRL_NET_FAULT 1
`define LAMP_CTRL_HEAD_FAULT 2
`define LAMP_CTRL_KEY 3
`define LAMP_CTRL_RESET 4'h0

`endif

/* File: hw/lamp_pkg.sv */
package lamp_pkg;

  typedef enum logic [2:0] {
    ST_STARTUP = 3'b000,
    ST_RESTORE = 3'b001,
    ST_NET_FAULT = 3'b010,
    ST_HEAD_FAULT = 3'b011,
    ST_READY = 3'b100
  } lamp_state_e;

endpackage : lamp_pkg

/* File: hw/blink_if.sv */
`timescale 1ns/1ps
interface blink_if;
  logic phase;
  modport src (output phase);
  modport dst (input phase);
endinterface : blink_if

/* File: hw/blink_divider.sv */
`timescale 1ns/1ps
module blink_divider #(
  parameter int unsigned HALF = 2
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  blink_if.src out
);
  logic [31:0] count;

  // Toggles the phase every HALF cycles.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      count <= 32'h0;
      out.phase <= 1'b0;
    end
    else if (count == 32'(HALF - 1))
    begin
      count <= 32'h0;
      out.phase <= ~out.phase;
    end
    else
    begin
      count <= count + 32'h1;
    end
  end
endmodule : blink_divider

/* File: hw/status_lamp_indicator.sv */
// Functional notes
// R1: Compact tri-colour lamp is always lit in some colour while powered; code lets it go dark in the off phase of the network-fault red blink.
// R2: Compact lamp holds steady red from power-up until start-up completes.
// R3: Start-up ends about ten seconds after power is applied.
// R4: Network fault after start-up blinks the compact lamp red quickly.
// R5: Network connected: steady yellow with key present, otherwise steady green.
// R6: Address restore alternates compact lamp red and green from power-up.
// R7: Modular adapter mirrors reader state on green, yellow and red lamps.
// R8: Modular adapter shows network state on run lamp and fault lamp.
// R9: During start-up the run lamp blinks at 2 Hz.
// R10: Network error lights run lamp and fault lamp steadily.
// R11: Reader error without key: run on, green and red blink, yellow off.
// R12: Reader error with key: run on, green and yellow blink, red off.
// R13: Ready: run on, fault off, green on; key adds yellow, remote shows yellow.
// R14: Address restore blinks run lamp and fault lamp at 1 Hz.
// R15: Restore is entered only when the switch is on at power-up.
// R16: Blink rates come from clock dividers; paired lamps blink in phase.
// R17: Priority: start-up, restore, network fault, reader fault, ready and key; code ranks restore above start-up.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "lamp_cfg.svh"
module status_lamp_indicator #(
  parameter int unsigned STARTUP_CYC = `LAMP_STARTUP_CYC,
  parameter int unsigned FAST_HALF = `LAMP_FAST_HALF,
  parameter int unsigned RUN_HALF = `LAMP_RUN_HALF,
  parameter int unsigned RESTORE_HALF = `LAMP_RESTORE_HALF
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic default_addr_restore_switch_i,
  input wire logic restore_done_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic tri_red_o,
  output logic tri_green_o,
  output logic remote_red_o,
  output logic remote_green_o,
  output logic run_lamp_o,
  output logic eth_fault_lamp_o,
  output logic head_green_lamp_o,
  output logic head_yellow_lamp_o,
  output logic head_fault_lamp_o
);
  blink_if fast_bl ();
  blink_if run_bl ();
  blink_if rst_bl ();

  // One shared divider per rate keeps paired lamps in phase. [R16]
  blink_divider #(.HALF(FAST_HALF)) u_fast (.clk_i(clk_i), .resetn_i(resetn_i), .out(fast_bl.src));
  blink_divider #(.HALF(RUN_HALF)) u_run (.clk_i(clk_i), .resetn_i(resetn_i), .out(run_bl.src));
  blink_divider #(.HALF(RESTORE_HALF)) u_rst (.clk_i(clk_i), .resetn_i(resetn_i), .out(rst_bl.src));

  logic [3:0] ctrl;
  logic [31:0] startup_count;
  logic startup_done;
  logic sampled;
  logic restore_active;
  lamp_pkg::lamp_state_e state;
  lamp_pkg::lamp_state_e next_state;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl <= `LAMP_CTRL_RESET;
    end
    else if (wr_i && addr_i == `LAMP_REG_CTRL)
    begin
      ctrl <= wdata_i[3:0];
    end
  end

  // Start-up timer runs from reset release for the fixed hold time. [R3]
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      startup_count <= 32'h0;
      startup_done <= 1'b0;
    end
    else if (!startup_done)
    begin
      if (startup_count == 32'(STARTUP_CYC - 1))
      begin
        startup_done <= 1'b1;
      end
      else
      begin
        startup_count <= startup_count + 32'h1;
      end
    end
  end

  // Marks that the first edge after reset release has passed. [R15]
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sampled <= 1'b0;
    end
    else
    begin
      sampled <= 1'b1;
    end
  end

  // The restore switch is caught once after reset release and holds until start-up is done and the address is adopted. [R15]
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      restore_active <= 1'b0;
    end
    else if (!sampled)
    begin
      restore_active <= default_addr_restore_switch_i;
    end
    else if (restore_done_i && startup_done)
    begin
      restore_active <= 1'b0;
    end
  end

  // Restore shows from power-up, so it outranks start-up here; start-up
  // still outranks every other condition. [R17] [R6]
  always_comb
  begin
    if (restore_active)
    begin
      next_state = lamp_pkg::ST_RESTORE;
    end
    else if (!startup_done)
    begin
      next_state = lamp_pkg::ST_STARTUP;
    end
    else if (ctrl[`LAMP_CTRL_NET_FAULT] || !ctrl[`LAMP_CTRL_NET_UP])
    begin
      next_state = lamp_pkg::ST_NET_FAULT;
    end
    else if (ctrl[`LAMP_CTRL_HEAD_FAULT])
    begin
      next_state = lamp_pkg::ST_HEAD_FAULT;
    end
    else
    begin
      next_state = lamp_pkg::ST_READY;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= lamp_pkg::ST_STARTUP;
    end
    else
    begin
      state <= next_state;
    end
  end

  logic key;
  assign key = ctrl[`LAMP_CTRL_KEY];

  // Compact tri-colour lamp: red plus green makes yellow.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tri_red_o <= 1'b1;
      tri_green_o <= 1'b0;
    end
    else
    begin
      case (state)
        lamp_pkg::ST_STARTUP:
        begin
          tri_red_o <= 1'b1; // [R2] [R1]
          tri_green_o <= 1'b0;
        end
        lamp_pkg::ST_RESTORE:
        begin
          tri_red_o <= rst_bl.phase; // [R6]
          tri_green_o <= ~rst_bl.phase;
        end
        lamp_pkg::ST_NET_FAULT:
        begin
          tri_red_o <= fast_bl.phase; // [R4]
          tri_green_o <= 1'b0;
        end
        // A reader fault blinks one half against a steady other, so the lamp never goes dark.
        lamp_pkg::ST_HEAD_FAULT:
        begin
          tri_red_o <= ~key | fast_bl.phase; // [R1]
          tri_green_o <= key | fast_bl.phase;
        end
        default:
        begin
          tri_red_o <= key; // [R5]
          tri_green_o <= 1'b1;
        end
      endcase
    end
  end

  // Remote single lamp: with a key the ready state shows yellow only. [R7] [R13]
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      remote_red_o <= 1'b1;
      remote_green_o <= 1'b0;
    end
    else
    begin
      case (state)
        lamp_pkg::ST_STARTUP:
        begin
          remote_red_o <= 1'b1;
          remote_green_o <= 1'b0;
        end
        lamp_pkg::ST_RESTORE:
        begin
          remote_red_o <= rst_bl.phase;
          remote_green_o <= ~rst_bl.phase;
        end
        lamp_pkg::ST_NET_FAULT:
        begin
          remote_red_o <= fast_bl.phase;
          remote_green_o <= 1'b0;
        end
        lamp_pkg::ST_HEAD_FAULT:
        begin
          remote_red_o <= ~key | fast_bl.phase;
          remote_green_o <= key | fast_bl.phase;
        end
        default:
        begin
          remote_red_o <= key; // [R13]
          remote_green_o <= 1'b1;
        end
      endcase
    end
  end

  // Modular network run lamp and fault lamp. [R8]
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      run_lamp_o <= 1'b0;
      eth_fault_lamp_o <= 1'b0;
    end
    else
    begin
      case (state)
        lamp_pkg::ST_STARTUP:
        begin
          run_lamp_o <= run_bl.phase; // [R9]
          eth_fault_lamp_o <= 1'b0;
        end
        lamp_pkg::ST_RESTORE:
        begin
          run_lamp_o <= rst_bl.phase; // [R14]
          eth_fault_lamp_o <= rst_bl.phase;
        end
        lamp_pkg::ST_NET_FAULT:
        begin
          run_lamp_o <= 1'b1; // [R10]
          eth_fault_lamp_o <= 1'b1;
        end
        lamp_pkg::ST_HEAD_FAULT:
        begin
          run_lamp_o <= 1'b1; // [R11] [R12]
          eth_fault_lamp_o <= 1'b0;
        end
        default:
        begin
          run_lamp_o <= 1'b1; // [R13]
          eth_fault_lamp_o <= 1'b0;
        end
      endcase
    end
  end

  // Modular reader-head lamps mirror the reader state. [R7]
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      head_green_lamp_o <= 1'b0;
      head_yellow_lamp_o <= 1'b0;
      head_fault_lamp_o <= 1'b0;
    end
    else
    begin
      case (state)
        lamp_pkg::ST_STARTUP:
        begin
          head_green_lamp_o <= 1'b0;
          head_yellow_lamp_o <= 1'b0;
          head_fault_lamp_o <= 1'b1;
        end
        lamp_pkg::ST_RESTORE:
        begin
          head_green_lamp_o <= 1'b0;
          head_yellow_lamp_o <= 1'b0;
          head_fault_lamp_o <= 1'b0;
        end
        lamp_pkg::ST_NET_FAULT:
        begin
          head_green_lamp_o <= 1'b0;
          head_yellow_lamp_o <= 1'b0;
          head_fault_lamp_o <= 1'b0;
        end
        lamp_pkg::ST_HEAD_FAULT:
        begin
          head_green_lamp_o <= fast_bl.phase; // [R11] [R12]
          head_yellow_lamp_o <= key & fast_bl.phase;
          head_fault_lamp_o <= ~key & fast_bl.phase;
        end
        default:
        begin
          head_green_lamp_o <= 1'b1; // [R13]
          head_yellow_lamp_o <= key;
          head_fault_lamp_o <= 1'b0;
        end
      endcase
    end
  end

  // Register reads answer one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_o <= 32'h0;
    end
    else if (rd_i)
    begin
      if (addr_i == `LAMP_REG_CTRL)
      begin
        rdata_o <= {28'h0, ctrl};
      end
      else if (addr_i == `LAMP_REG_STATUS)
      begin
        rdata_o <= {26'h0, restore_active, startup_done, 1'b0, state};
      end
      else if (addr_i == `LAMP_REG_LAMPS)
      begin
        rdata_o <= {25'h0, tri_red_o, tri_green_o, run_lamp_o, eth_fault_lamp_o,
                    head_green_lamp_o, head_yellow_lamp_o, head_fault_lamp_o};
      end
      else
      begin
        rdata_o <= 32'h0;
      end
    end
    else
    begin
      rdata_o <= 32'h0;
    end
  end
endmodule : status_lamp_indicator

/* File: bench/lamp_panel_model.sv */
`timescale 1ns/1ps
// Front panel: the compact lamp and the remote single lamp.
module lamp_panel_model (
  input wire logic red_i,
  input wire logic green_i,
  input wire logic rem_red_i,
  input wire logic rem_green_i,
  output logic lit_o,
  output logic rem_yellow_o
);
  assign lit_o = red_i | green_i;
  assign rem_yellow_o = rem_red_i & rem_green_i;
endmodule : lamp_panel_model

/* File: bench/lamp_monitor.sv */
`timescale 1ns/1ps
module lamp_monitor #(
  parameter int unsigned STARTUP_CYC = 50,
  parameter int unsigned RUN_HALF = 5,
  parameter int unsigned RESTORE_HALF = 10
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic default_addr_restore_switch_i,
  input wire logic restore_done_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic tri_red_o,
  input wire logic tri_green_o,
  input wire logic run_lamp_o,
  input wire logic eth_fault_lamp_o,
  input wire logic head_yellow_lamp_o,
  input wire logic head_fault_lamp_o
);
  logic [31:0] cnt;
  logic [31:0] gap;
  logic rest;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i) cnt <= '0;
    else if (cnt < STARTUP_CYC + 8) cnt <= cnt + 1;
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i) rest <= 1'b0;
    else if (cnt == 0) rest <= default_addr_restore_switch_i;
  // Cycles since the run lamp last changed.
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i) gap <= '0;
    else gap <= $changed(run_lamp_o) ? 32'h1 : gap + 1;
  sequence s_run_toggle;
    $changed(run_lamp_o);
  endsequence
  wire late = cnt > STARTUP_CYC + 4 && !rest;
  wire restoring = rest && !restore_done_i;
  chk_startup_red: assert property (cnt < STARTUP_CYC && !rest |-> tri_red_o && !tri_green_o)
    else $error("lamp not steady red in start-up");
  chk_run_rate: assert property ((cnt > 3 * RUN_HALF && cnt < STARTUP_CYC && !rest) ##0 s_run_toggle
    |-> gap == RUN_HALF) else $error("run blink rate wrong in start-up");
  chk_restore_rate: assert property ((cnt > 3 * RESTORE_HALF && restoring) ##0 s_run_toggle
    |-> gap == RESTORE_HALF) else $error("run blink rate wrong in restore");
  chk_fault_with_run: assert property (late && eth_fault_lamp_o |-> run_lamp_o)
    else $error("fault lamp lit without run lamp");
  chk_restore_pair: assert property (restoring |-> run_lamp_o == eth_fault_lamp_o)
    else $error("restore lamps out of phase");
  chk_restore_alt: assert property (restoring |-> tri_red_o != tri_green_o)
    else $error("compact lamp not alternating in restore");
  chk_key_excl: assert property (late |-> !(head_yellow_lamp_o && head_fault_lamp_o))
    else $error("yellow and red head lamps both lit");
  chk_compact_lit: assert property (late && !eth_fault_lamp_o |-> tri_red_o || tri_green_o)
    else $error("compact lamp dark after start-up");
  chk_rd_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
endmodule : lamp_monitor
bind status_lamp_indicator lamp_monitor #(.STARTUP_CYC(STARTUP_CYC), .RUN_HALF(RUN_HALF),
  .RESTORE_HALF(RESTORE_HALF)) mon (.clk_i(clk_i), .resetn_i(resetn_i),
  .default_addr_restore_switch_i(default_addr_restore_switch_i), .restore_done_i(restore_done_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .tri_red_o(tri_red_o), .tri_green_o(tri_green_o),
  .run_lamp_o(run_lamp_o), .eth_fault_lamp_o(eth_fault_lamp_o),
  .head_yellow_lamp_o(head_yellow_lamp_o), .head_fault_lamp_o(head_fault_lamp_o));

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam int SU = 50;
  localparam int FH = 3;
  localparam int RH = 5;
  localparam int AH = 10;
  logic clk, resetn, sw, done, wr, rd, lit, ry;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic rr, rg, tr, tg, run, ef, hg, hy, hf;
  logic [8:0] lv;
  int fails, checks_done;
  logic [3:0] cv [5] = '{4'h1, 4'h9, 4'h3, 4'h7, 4'hF};
  logic [8:0] mk [5] = '{9'h1FF, 9'h1FF, 9'h018, 9'h018, 9'h018};
  logic [8:0] ex [5] = '{9'h0B4, 9'h1F6, 9'h018, 9'h018, 9'h018};
  logic [31:0] st [5] = '{32'h14, 32'h14, 32'h12, 32'h12, 32'h12};
  assign lv = {rr, rg, tr, tg, run, ef, hg, hy, hf};
  status_lamp_indicator #(.STARTUP_CYC(SU), .FAST_HALF(FH), .RUN_HALF(RH), .RESTORE_HALF(AH)) dut (
    .clk_i(clk), .resetn_i(resetn), .default_addr_restore_switch_i(sw), .restore_done_i(done),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tri_red_o(tr),
    .tri_green_o(tg), .remote_red_o(rr), .remote_green_o(rg), .run_lamp_o(run),
    .eth_fault_lamp_o(ef), .head_green_lamp_o(hg), .head_yellow_lamp_o(hy), .head_fault_lamp_o(hf));
  lamp_panel_model panel (.red_i(tr), .green_i(tg), .rem_red_i(rr), .rem_green_i(rg),
    .lit_o(lit), .rem_yellow_o(ry));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(n, e, rdata);
  endtask : rd_chk
  // Syncs to one toggle of a lamp, then counts cycles to the next toggle.
  task automatic period(input int i, input int e, input string n);
    logic v;
    int c;
    for (int k = 0; k < 2; k++)
    begin
      v = lv[i];
      c = 0;
      do
      begin
        wait_n(1);
        c++;
      end while (lv[i] === v && c < 100);
    end
    chk(n, e, c);
  endtask : period
  task automatic head(input logic [3:0] c, input logic k);
    int t;
    logic p;
    wr_reg(4'h0, {28'h0, c});
    wait_n(4);
    t = 0;
    p = hg;
    repeat (16)
    begin
      wait_n(1);
      chk("head lamps", {1'b1, k ? hg : 1'b0, k ? 1'b0 : hg}, {run, hy, hf});
      chk("head lit", 1'b1, lit);
      t += int'(hg !== p);
      p = hg;
    end
    chk("head blink", 1, t > 0);
  endtask : head
  task end_of_test;
    if (fails == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    fails++;
    end_of_test();
  end
  initial
  begin
    {resetn, sw, done, wr, rd, addr, wdata} = '0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    period(4, RH, "run blink");
    chk("startup red", 2'b10, {tr, tg});
    @(posedge clk);
    sw <= 1'b1;
    wait_n(SU);
    rd_chk(4'h4, 32'h12, "status");
    chk("net fault", 2'b11, {run, ef});
    period(6, FH, "fast red");
    chk("red only", 1'b0, tg);
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(4'h0, {28'h0, cv[i]});
      wait_n(4);
      chk("lamps", ex[i], lv & mk[i]);
      rd_chk(4'h4, st[i], "state");
      if (i < 2)
      begin
        chk("lit", 1'b1, lit);
        chk("remote yellow", cv[i][3], ry);
        rd_chk(4'h8, {25'h0, ex[i][6:0]}, "lamp reg");
      end
    end
    head(4'h5, 1'b0);
    head(4'hD, 1'b1);
    rd_chk(4'h0, 32'hD, "ctrl");
    wr_reg(4'h4, 32'hFF);
    rd_chk(4'h4, 32'h13, "status ro");
    rd_chk(4'hC, 32'h0, "unmapped");
    resetn <= 1'b0;
    wait_n(3);
    resetn <= 1'b1;
    period(4, AH, "restore run");
    chk("restore alt", 1'b1, tr ^ tg);
    wait_n(SU);
    rd_chk(4'h4, 32'h31, "restore status");
    @(posedge clk);
    done <= 1'b1;
    wr_reg(4'h0, 32'h1);
    wait_n(4);
    rd_chk(4'h4, 32'h14, "restore end");
    end_of_test();
  end
endmodule : testbench
